// file: bdec_cpu_model.sv
// Purpose: Behavioural model of the on-board CPU bus that drives the decoder.
// Assumes: One request at a time; ack is sampled on the falling edge.
// Notes:   A released request bus shows inverted data, never the stale value.
`timescale 1ns/1ps
`default_nettype none
module bdec_cpu_model
    import bdec_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       req_ack,
    input  wire logic [7:0] rdata,
    input  wire bdec_sel_t  sel,
    output logic            req_valid,
    output bdec_req_t       req
);
    ////////////////////////////////////////////////////////////////////////////////
    // Idle bus at time zero
    initial begin
        req_valid = 1'b0;
        req = '0;
    end

    // One bus cycle; held until ack is seen, answer taken in the ack cycle
    task automatic access(input logic [15:0] a, input logic io, input logic wr, input logic [7:0] wd,
                          output logic [7:0] rd, output bdec_sel_t sl, output int n);
        @(posedge core_clk);
        #1;
        req_valid = 1'b1;
        req = '{addr: a, is_io: io, is_write: wr, wdata: wd};
        n = 0;
        do begin
            @(negedge core_clk);
            n++;
        end while (req_ack !== 1'b1 && n < 50);
        rd = rdata;
        sl = sel;
        @(posedge core_clk);
        #1;
        req_valid = 1'b0;
        req = bdec_req_t'(~req); // Stale bus value would hide decode slips
    endtask

    // Two-write count load to a single port, low byte first
    task automatic load16(input logic [7:0] port, input logic [15:0] v);
        logic [7:0] rd;
        bdec_sel_t  sl;
        int         n;
        access({8'h00, port}, 1'b1, 1'b1, v[7:0], rd, sl, n);
        access({8'h00, port}, 1'b1, 1'b1, v[15:8], rd, sl, n);
    endtask
endmodule // bdec_cpu_model
`default_nettype wire

// file: bdec_pkg.sv
// Purpose: Shared constants and types for the board address decoder.
// Assumes: 8-bit CPU with 16-bit memory space and 8-bit I/O space.
// Notes:   Offsets and reset values live here; the one-cycle EPROM wait is set by the decoder's ST_WAIT state.
`default_nettype none
package bdec_pkg;
    // On-board EPROM window ends, by installed part size
    localparam logic [15:0] ROM_END_4K   = 16'h0fff;
    localparam logic [15:0] ROM_END_8K   = 16'h1fff;
    localparam logic [15:0] ROM_END_16K  = 16'h3fff;
    localparam logic [15:0] ROM_END_32K  = 16'h7fff;
    // On-board RAM window start inside its 16K segment
    localparam logic [13:0] RAM_OFS_DEF  = 14'h3000;
    localparam logic [13:0] RAM_OFS_EXP  = 14'h2000;
    localparam logic [1:0]  RAM_SEG_DEF  = 2'h0;
    // I/O addresses
    localparam logic [7:0]  PIC_PORT_A   = 8'hd8;
    localparam logic [7:0]  PIC_PORT_B   = 8'hd9;
    localparam logic [7:0]  PIC_ALIAS_A  = 8'hda;
    localparam logic [7:0]  PIC_ALIAS_B  = 8'hdb;
    localparam logic [7:0]  CNT_CH0_PORT = 8'hdc;
    localparam logic [7:0]  CNT_CH1_PORT = 8'hdd;
    localparam logic [7:0]  BAUD_FACTOR_PORT = 8'hde;
    localparam logic [7:0]  CNT_CTRL_PORT = 8'hdf;
    localparam logic [7:0]  BOARD_CTRL_PORT = 8'hd4;
    // Board control bits and reset value
    localparam int          CTRL_BANK_BIT = 0;
    localparam int          CTRL_ROM_BIT  = 1;
    localparam logic [7:0]  CTRL_RESET    = 8'h02;
    // Interrupt controller fields and reset values
    localparam int          PIC_ISR_BIT   = 0;
    localparam int          PIC_POLL_BIT  = 2;
    localparam int          PIC_INIT_BIT  = 4;
    localparam logic [7:0]  PIC_MASK_RESET = 8'hff;
    localparam logic [7:0]  PIC_BLOCK_RESET = 8'h00;
    localparam logic [7:0]  PIC_CMD_RESET = 8'h00;
    // Counter control word channel field
    localparam int          CW_SEL_LSB    = 6;
    // Fixed CPU interrupt vectors
    localparam logic [7:0]  VEC_TRAP = 8'h24;
    localparam logic [7:0]  VEC_R75  = 8'h3c;
    localparam logic [7:0]  VEC_R65  = 8'h34;
    localparam logic [7:0]  VEC_R55  = 8'h2c;
    // Counter reference and core rates
    localparam int          REF_CLK_HZ  = 1075200;
    localparam int          CORE_CLK_HZ = 200000000;
    localparam int          ROM_WAIT_CYCLES = 1;

    typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_WAIT = 2'b01, ST_ACK = 2'b11} bdec_state_t;
    typedef struct packed {
        logic [15:0] addr;
        logic        is_io;
        logic        is_write;
        logic [7:0]  wdata;
    } bdec_req_t;
    typedef struct packed {
        logic rom;
        logic ram;
        logic sysbus;
        logic timer;
        logic pic;
        logic board;
    } bdec_sel_t;
    typedef struct packed {
        logic [1:0] rom_size;
        logic       rom_fast;
        logic       ram_exp;
        logic [1:0] ram_seg;
        logic [1:0] bank_jmp;
        logic       rom_jmp;
    } bdec_strap_t;
endpackage
`default_nettype wire

// file: bdec_top.sv
// Purpose: Board address decode: memory windows, wait states, I/O selects,
//          two-write counter loads, interrupt register steering, vectors.
// Assumes: One CPU request outstanding; straps and interrupt pins are async.
// Notes:   Peripheral cores sit outside; this block holds their port state.
// Behaviour
// - Slow EPROM from zero, sized, one wait
// - Fast EPROM up to 7FFF, no wait
// - RAM 3000-3FFF, 2000-3FFF when expanded
// - RAM relocatable to any 16K segment top
// - Bank select bit qualified by two jumpers
// - ROM select off disables EPROM decode
// - Counter ports DC, DD, DE, control DF
// - DE holds 16-bit baud factor
// - Interrupt controller at D8/DA and D9/DB
// - Shared port register chosen by sequence, bit
// - Four fixed vectors, only trap unmaskable
// - Channel two drives the baud generator
// - Counter clock from 1.0752 MHz reference
`timescale 1ns/1ps
`default_nettype none
module bdec_top
    import bdec_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        req_valid,
    input  wire bdec_req_t   req,
    output logic             req_ack,
    output logic [7:0]       rdata,
    output bdec_sel_t        sel,
    output logic             bank_a16,
    input  wire bdec_strap_t strap_pins,
    input  wire logic [7:0]  pic_request,
    input  wire logic [7:0]  pic_in_service,
    output logic [7:0]       irq_mask,
    output logic [7:0]       irq_vector_block_base,
    output logic [7:0]       irq_command,
    output logic [15:0]      baud_factor,
    output logic [2:0]       count_loaded,
    output logic             timer_clk_tick,
    input  wire logic [3:0]  cpu_int_pins,
    input  wire logic [2:0]  cpu_int_mask,
    output logic             vec_valid,
    output logic [7:0]       vec_addr
);
    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: straps and interrupt pins are asynchronous
    localparam int SYNC_W = $bits(bdec_strap_t) + 4;
    logic [SYNC_W-1:0] sync_a;
    logic [SYNC_W-1:0] sync_b;
    bdec_strap_t       strap;
    logic [3:0]        int_s;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            sync_a <= '0;
            sync_b <= '0;
        end else begin
            sync_a <= {strap_pins, cpu_int_pins};
            sync_b <= sync_a;
        end
    end
    assign strap = bdec_strap_t'(sync_b[SYNC_W-1:4]);
    assign int_s = sync_b[3:0];
    ////////////////////////////////////////////////////////////////////////
    // Memory decode
    logic [7:0]  board_ctrl;
    logic        rom_enabled;
    logic [15:0] rom_end;
    logic [13:0] ram_ofs;
    logic        hit_rom;
    logic        hit_ram;
    logic        rom_needs_wait;
    assign rom_enabled = !(strap.rom_jmp && !board_ctrl[CTRL_ROM_BIT]);
    assign rom_end = strap.rom_fast ? ROM_END_32K :
                     (strap.rom_size == 2'd0) ? ROM_END_4K :
                     (strap.rom_size == 2'd1) ? ROM_END_8K : ROM_END_16K;
    assign ram_ofs = strap.ram_exp ? RAM_OFS_EXP : RAM_OFS_DEF;
    // Segment jumper moves the window to the top of any 16K boundary
    assign hit_ram = !req.is_io && (req.addr[15:14] == strap.ram_seg)
                     && (req.addr[13:0] >= ram_ofs);
    // RAM wins an overlap so a relocated window stays usable
    assign hit_rom = !req.is_io && rom_enabled && !hit_ram && (req.addr <= rom_end);
    assign rom_needs_wait = hit_rom && !strap.rom_fast;
    ////////////////////////////////////////////////////////////////////////
    // I/O decode; the interrupt controller answers on both aliases
    logic [7:0] io_a;
    logic       hit_pic_a;
    logic       hit_pic_b;
    logic       hit_cnt_data;
    logic       hit_cnt_ctrl;
    logic       hit_board;
    logic       hit_timer;
    logic       hit_pic;
    logic [1:0] cnt_ch;
    bdec_sel_t  next_sel;
    assign io_a         = req.addr[7:0];
    assign hit_pic_a    = req.is_io && ((io_a == PIC_PORT_A) || (io_a == PIC_ALIAS_A));
    assign hit_pic_b    = req.is_io && ((io_a == PIC_PORT_B) || (io_a == PIC_ALIAS_B));
    assign hit_cnt_data = req.is_io && (io_a >= CNT_CH0_PORT) && (io_a <= BAUD_FACTOR_PORT);
    assign hit_cnt_ctrl = req.is_io && (io_a == CNT_CTRL_PORT);
    assign hit_board    = req.is_io && (io_a == BOARD_CTRL_PORT);
    assign cnt_ch       = io_a[1:0];
    assign hit_timer    = hit_cnt_data || hit_cnt_ctrl;
    assign hit_pic      = hit_pic_a || hit_pic_b;
    // Anything no local window claims goes out to the system bus
    assign next_sel = '{rom: hit_rom, ram: hit_ram, timer: hit_timer, pic: hit_pic, board: hit_board,
                        sysbus: !(hit_rom || hit_ram || hit_timer || hit_pic || hit_board)};
    ////////////////////////////////////////////////////////////////////////
    // Request sequencing: take, optional EPROM wait, acknowledge
    bdec_state_t state;
    bdec_state_t next_state;
    logic        take;
    assign take    = (state == ST_IDLE) && req_valid;
    assign req_ack = (state == ST_ACK);
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (req_valid) begin
                    next_state = rom_needs_wait ? ST_WAIT : ST_ACK;
                end
            end
            ST_WAIT: next_state = ST_ACK;
            ST_ACK:  next_state = ST_IDLE;
            default: next_state = ST_IDLE;
        endcase
    end

    // Selects stand from the take edge until the acknowledge ends
    always_ff @(posedge core_clk) begin
        if (rst) begin
            state <= ST_IDLE;
            sel   <= '0;
        end else begin
            state <= next_state;
            sel   <= take ? next_sel : (req_ack ? '0 : sel);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Board control port: bank select and on-board ROM select
    logic wr_io;
    logic rd_io;
    assign wr_io = take && req.is_write;
    assign rd_io = take && !req.is_write;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            board_ctrl <= CTRL_RESET;
        end else if (wr_io && hit_board) begin
            board_ctrl <= req.wdata;
        end
    end
    assign bank_a16 = board_ctrl[CTRL_BANK_BIT] && (&strap.bank_jmp);
    ////////////////////////////////////////////////////////////////////////
    // Counter data ports: byte pointer pairs two writes into one count
    logic [15:0] count_val [3];
    logic [2:0]  byte_hi;
    logic [1:0]  cw_ch;
    assign cw_ch = req.wdata[CW_SEL_LSB +: 2];
    generate
        for (genvar i = 0; i < 3; i++) begin : g_cnt
            logic hit_i;
            assign hit_i = hit_cnt_data && (cnt_ch == 2'(i));
            always_ff @(posedge core_clk) begin
                if (rst) begin
                    count_val[i]    <= '0;
                    byte_hi[i]      <= 1'b0;
                    count_loaded[i] <= 1'b0;
                end else begin
                    count_loaded[i] <= wr_io && hit_i && byte_hi[i];
                    if (wr_io && hit_cnt_ctrl && (cw_ch == 2'(i))) begin
                        byte_hi[i] <= 1'b0;             // Control word restarts pairing
                    end else if (take && hit_i) begin
                        byte_hi[i] <= !byte_hi[i];
                    end
                    if (wr_io && hit_i && !byte_hi[i]) begin
                        count_val[i][7:0] <= req.wdata;
                    end
                    if (wr_io && hit_i && byte_hi[i]) begin
                        count_val[i][15:8] <= req.wdata;
                    end
                end
            end
        end
    endgenerate
    // Channel two doubles as the serial baud generator
    assign baud_factor = count_val[2];
    // Counter clock enable from a phase accumulator at the reference rate
    logic [27:0] phase;
    logic [28:0] phase_sum;
    assign phase_sum = {1'b0, phase} + 29'(REF_CLK_HZ);
    always_ff @(posedge core_clk) begin
        if (rst) begin
            phase          <= '0;
            timer_clk_tick <= 1'b0;
        end else if (phase_sum >= 29'(CORE_CLK_HZ)) begin
            phase          <= 28'(phase_sum - 29'(CORE_CLK_HZ));
            timer_clk_tick <= 1'b1;
        end else begin
            phase          <= phase_sum[27:0];
            timer_clk_tick <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt controller ports: shared addresses steered by sequence
    logic       block_armed;
    logic       poll_armed;
    logic [7:0] poll_status;
    logic       any_req;
    logic [2:0] top_req;

    // Lowest numbered request is highest priority in the poll word
    always_comb begin
        top_req = 3'd0;
        for (int j = 7; j >= 0; j--) begin
            if (pic_request[j]) begin
                top_req = 3'(j);
            end
        end
    end
    assign any_req     = |pic_request;
    assign poll_status = {any_req, 4'h0, top_req};
    always_ff @(posedge core_clk) begin
        if (rst) begin
            irq_command           <= PIC_CMD_RESET;
            irq_mask              <= PIC_MASK_RESET;
            irq_vector_block_base <= PIC_BLOCK_RESET;
            block_armed           <= 1'b0;
            poll_armed            <= 1'b0;
        end else begin
            if (wr_io && hit_pic_a) begin
                irq_command <= req.wdata;
                block_armed <= req.wdata[PIC_INIT_BIT];
                poll_armed  <= req.wdata[PIC_POLL_BIT];
            end else if (rd_io && hit_pic_a) begin
                poll_armed  <= 1'b0;               // Poll answer is given once
            end
            if (wr_io && hit_pic_b) begin
                if (block_armed) begin
                    irq_vector_block_base <= req.wdata;
                    block_armed           <= 1'b0;
                end else begin
                    irq_mask <= req.wdata;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data, captured at the take edge
    logic [7:0] next_rdata;
    logic [7:0] cnt_rd;
    assign cnt_rd = byte_hi[cnt_ch] ? count_val[cnt_ch][15:8] : count_val[cnt_ch][7:0];
    assign next_rdata = (hit_pic_a && poll_armed) ? poll_status :
                        hit_pic_a ? (irq_command[PIC_ISR_BIT] ? pic_in_service : pic_request) :
                        hit_pic_b ? irq_mask :
                        hit_cnt_data ? cnt_rd :
                        hit_board ? board_ctrl : 8'h00;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            rdata <= '0;
        end else if (rd_io) begin
            rdata <= next_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Direct CPU interrupt vectors: bit 3 trap, 2..0 maskable levels
    logic [2:0] int_live;
    assign int_live = int_s[2:0] & ~cpu_int_mask;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            vec_valid <= 1'b0;
            vec_addr  <= '0;
        end else begin
            vec_valid <= int_s[3] || (|int_live);
            vec_addr  <= int_s[3] ? VEC_TRAP :
                         int_live[2] ? VEC_R75 :
                         int_live[1] ? VEC_R65 :
                         int_live[0] ? VEC_R55 : 8'h00;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Assertions
    sequence s_one_wait;
        !req_ack ##1 req_ack;
    endsequence
    property p_slow_rom_wait;
        @(posedge core_clk) disable iff (rst) (take && rom_needs_wait) |=> s_one_wait ##1 !req_ack;
    endproperty
    a_slow_rom_wait: assert property (p_slow_rom_wait) else $error("Slow EPROM wait missing");
    property p_fast_rom;
        @(posedge core_clk) disable iff (rst) (take && hit_rom && strap.rom_fast) |=> req_ack && sel.rom;
    endproperty
    a_fast_rom: assert property (p_fast_rom) else $error("Fast EPROM access delayed");
    property p_ram_window;
        @(posedge core_clk) disable iff (rst)
            (take && !req.is_io && req.addr[15:14] == strap.ram_seg && req.addr[13:12] == 2'h3) |=> sel.ram;
    endproperty
    a_ram_window: assert property (p_ram_window) else $error("RAM window not selected");
    property p_bank;
        @(posedge core_clk) disable iff (rst) bank_a16 |-> (&strap.bank_jmp) && board_ctrl[CTRL_BANK_BIT];
    endproperty
    a_bank: assert property (p_bank) else $error("Bank select without jumpers");
    property p_rom_off;
        @(posedge core_clk) disable iff (rst) (take && strap.rom_jmp && !board_ctrl[CTRL_ROM_BIT]) |=> !sel.rom;
    endproperty
    a_rom_off: assert property (p_rom_off) else $error("EPROM decoded while disabled");
    property p_high_byte;
        @(posedge core_clk) disable iff (rst)
            (wr_io && hit_cnt_data && cnt_ch == 2'd2 && byte_hi[2])
            |=> baud_factor[15:8] == $past(req.wdata) && !byte_hi[2] && count_loaded[2];
    endproperty
    a_high_byte: assert property (p_high_byte) else $error("Baud high byte not paired");
    property p_block_seq;
        @(posedge core_clk) disable iff (rst)
            (wr_io && hit_pic_b && block_armed) |=> irq_vector_block_base == $past(req.wdata) && $stable(irq_mask);
    endproperty
    a_block_seq: assert property (p_block_seq) else $error("Block address write misrouted");
    property p_trap_vec;
        @(posedge core_clk) disable iff (rst) int_s[3] |=> vec_valid && vec_addr == 8'h24;
    endproperty
    a_trap_vec: assert property (p_trap_vec) else $error("Trap vector wrong");
    property p_sysbus_only;
        @(posedge core_clk) disable iff (rst) sel.sysbus |-> !(sel.rom || sel.ram || sel.pic || sel.timer);
    endproperty
    a_sysbus_only: assert property (p_sysbus_only) else $error("System bus and local select together");
endmodule // bdec_top
`default_nettype wire

// file: tb_top.sv
// Purpose: Self-checking bench for the board address decoder.
// Assumes: Inputs change 1 ns after the rising edge; straps settle in 3 edges.
// Notes:   Tick rate is judged over a window, so it allows one tick of jitter.
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import bdec_pkg::*;
;
    localparam logic [5:0] S_ROM = 6'h20, S_RAM = 6'h10, S_SYS = 6'h08, S_TMR = 6'h04, S_PIC = 6'h02;
    logic        core_clk, rst, req_valid, req_ack, bank_a16, timer_clk_tick, vec_valid;
    bdec_req_t   req;
    bdec_sel_t   sel, sl_seen;
    bdec_strap_t strap_pins;
    logic [7:0]  rdata, pic_request, pic_in_service, irq_mask, irq_vector_block_base, irq_command, vec_addr;
    logic [7:0]  rd_seen;
    logic [15:0] baud_factor;
    logic [2:0]  count_loaded, loads_seen, cpu_int_mask;
    logic [3:0]  cpu_int_pins;
    int          n_seen, tick_seen, err_total, comparisons;
    logic [15:0] rom_in [4] = '{16'h0fff, 16'h1fff, 16'h2fff, 16'h7fff};
    logic [15:0] rom_out [4] = '{16'h1000, 16'h2000, 16'h4000, 16'h8000};
    logic [2:0]  vm [6] = '{3'h7, 3'h7, 3'h0, 3'h0, 3'h0, 3'h4};
    logic [3:0]  vp [6] = '{4'hf, 4'h7, 4'h7, 4'h3, 4'h1, 4'h6};
    logic [7:0]  va [6] = '{8'h24, 8'h00, 8'h3c, 8'h34, 8'h2c, 8'h34};

    ////////////////////////////////////////////////////////////////////////////////
    bdec_top bdec_top_i (.core_clk(core_clk), .rst(rst), .req_valid(req_valid), .req(req), .req_ack(req_ack),
        .rdata(rdata), .sel(sel), .bank_a16(bank_a16), .strap_pins(strap_pins), .pic_request(pic_request),
        .pic_in_service(pic_in_service), .irq_mask(irq_mask), .irq_vector_block_base(irq_vector_block_base),
        .irq_command(irq_command), .baud_factor(baud_factor), .count_loaded(count_loaded),
        .timer_clk_tick(timer_clk_tick), .cpu_int_pins(cpu_int_pins), .cpu_int_mask(cpu_int_mask),
        .vec_valid(vec_valid), .vec_addr(vec_addr));
    bdec_cpu_model cpu_i (.core_clk(core_clk), .req_ack(req_ack), .rdata(rdata), .sel(sel),
        .req_valid(req_valid), .req(req));

    // Clock and pulse collectors; pulses last one cycle so they are gathered
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        loads_seen <= loads_seen | count_loaded;
        tick_seen <= tick_seen + int'(timer_clk_tick);
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic acc(input logic [15:0] a, input logic io, input logic wr, input logic [7:0] wd);
        cpu_i.access(a, io, wr, wd, rd_seen, sl_seen, n_seen);
    endtask
    task automatic mchk(input logic [15:0] a, input logic [5:0] s);
        acc(a, 1'b0, 1'b0, 8'h00);
        chk(16'(sl_seen), {10'h000, s});
    endtask
    task automatic st(input logic [1:0] sz, input logic f, input logic e, input logic [1:0] sg,
                      input logic [1:0] bj, input logic rj);
        strap_pins = '{rom_size: sz, rom_fast: f, ram_exp: e, ram_seg: sg, bank_jmp: bj, rom_jmp: rj};
        repeat (3) @(posedge core_clk);
        #1;
    endtask
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Watchdog sized well above the ~20k cycles the tests need
    initial begin
        repeat (100000) @(posedge core_clk);
        err_total++;
        complete_run();
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        rst = 1'b1;
        err_total = 0;
        comparisons = 0;
        loads_seen = '0;
        tick_seen = 0;
        strap_pins = '0;
        pic_request = 8'h0c;
        pic_in_service = 8'h30;
        cpu_int_pins = 4'h0;
        cpu_int_mask = 3'h7;
        repeat (16) @(posedge core_clk);
        #1;
        rst = 1'b0;
        chk(16'(irq_mask), 16'h00ff);
        chk(baud_factor, 16'h0000);
        chk(16'(bank_a16), 16'h0000);
        acc(16'h00d4, 1'b1, 1'b0, 8'h00);
        chk(16'(rd_seen), 16'h0002);
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            st(i[1:0], i == 3, 1'b0, 2'h0, 2'h0, 1'b1);
            mchk(rom_in[i], S_ROM);
            chk(16'(n_seen), (i == 3) ? 16'h0002 : 16'h0003);
            mchk(rom_out[i], S_SYS);
        end
        $display("test rom done");
        st(2'h0, 1'b0, 1'b0, 2'h0, 2'h0, 1'b1);
        mchk(16'h3000, S_RAM);
        chk(16'(n_seen), 16'h0002);
        mchk(16'h2fff, S_SYS);
        st(2'h0, 1'b0, 1'b1, 2'h0, 2'h0, 1'b1);
        mchk(16'h2000, S_RAM);
        st(2'h0, 1'b0, 1'b0, 2'h2, 2'h0, 1'b1);
        mchk(16'hb000, S_RAM);
        mchk(16'h3000, S_SYS);
        $display("test ram done");
        acc(16'h00d4, 1'b1, 1'b1, 8'h00);
        mchk(16'h0100, S_SYS);
        acc(16'h00d4, 1'b1, 1'b1, 8'h03);
        mchk(16'h0100, S_ROM);
        st(2'h0, 1'b0, 1'b0, 2'h2, 2'h3, 1'b1);
        chk(16'(bank_a16), 16'h0001);
        st(2'h0, 1'b0, 1'b0, 2'h2, 2'h1, 1'b1);
        chk(16'(bank_a16), 16'h0000);
        acc(16'h00e4, 1'b1, 1'b0, 8'h00);
        chk({rd_seen, 2'h0, sl_seen}, {8'h00, 2'h0, S_SYS});
        $display("test board control done");
        // Reads move the byte pointers, so the control writes put them back
        for (int i = 0; i < 4; i++) begin
            acc(16'h00dc + 16'(i), 1'b1, 1'b0, 8'h00);
            chk(16'(sl_seen), {10'h000, S_TMR});
        end
        for (int i = 0; i < 3; i++) begin
            acc(16'h00df, 1'b1, 1'b1, {i[1:0], 6'h00});
        end
        loads_seen = '0;
        cpu_i.load16(8'hde, 16'h1255);
        chk(baud_factor, 16'h1255);
        chk(16'(loads_seen), 16'h0004);
        acc(16'h00de, 1'b1, 1'b1, 8'h34);
        acc(16'h00df, 1'b1, 1'b1, 8'h80);
        cpu_i.load16(8'hde, 16'h5678);
        chk(baud_factor, 16'h5678);
        loads_seen = '0;
        cpu_i.load16(8'hdc, 16'habcd);
        chk(16'(loads_seen), 16'h0001);
        acc(16'h00dc, 1'b1, 1'b0, 8'h00);
        chk(16'(rd_seen), 16'h00cd);
        acc(16'h00dc, 1'b1, 1'b0, 8'h00);
        chk(16'(rd_seen), 16'h00ab);
        $display("test counter done");
        acc(16'h00d9, 1'b1, 1'b1, 8'h5a);
        acc(16'h00db, 1'b1, 1'b0, 8'h00);
        chk({rd_seen, 2'h0, sl_seen}, {8'h5a, 2'h0, S_PIC});
        acc(16'h00da, 1'b1, 1'b1, 8'h10);
        chk(16'(irq_command), 16'h0010);
        acc(16'h00d9, 1'b1, 1'b1, 8'h40);
        chk({irq_vector_block_base, irq_mask}, 16'h405a);
        acc(16'h00db, 1'b1, 1'b1, 8'ha5);
        chk(16'(irq_mask), 16'h00a5);
        acc(16'h00d8, 1'b1, 1'b1, 8'h00);
        acc(16'h00d8, 1'b1, 1'b0, 8'h00);
        chk(16'(rd_seen), 16'h000c);
        acc(16'h00d8, 1'b1, 1'b1, 8'h01);
        acc(16'h00da, 1'b1, 1'b0, 8'h00);
        chk(16'(rd_seen), 16'h0030);
        acc(16'h00d8, 1'b1, 1'b1, 8'h04);
        acc(16'h00d8, 1'b1, 1'b0, 8'h00);
        chk(16'(rd_seen), 16'h0082);
        acc(16'h00d8, 1'b1, 1'b0, 8'h00);
        chk(16'(rd_seen), 16'h000c);
        $display("test interrupt registers done");
        for (int i = 0; i < 6; i++) begin
            cpu_int_mask = vm[i];
            cpu_int_pins = vp[i];
            repeat (4) @(posedge core_clk);
            #1;
            chk(16'(vec_valid), 16'(i != 1));
            if (i != 1) begin
                chk(16'(vec_addr), 16'(va[i]));
            end
        end
        $display("test vectors done");
        // 20000 cycles at 200 MHz hold 107.52 reference periods
        tick_seen = 0;
        repeat (20000) @(posedge core_clk);
        #1;
        chk(16'(tick_seen >= 107 && tick_seen <= 108), 16'h0001);
        $display("test reference tick done");
        complete_run();
    end
endmodule // tb_top
`default_nettype wire
